// file: rtl/cpmc_pkg.sv
// Constants and types of the privilege and mode control block.
package cpmc_pkg;

	// ========================================================
	// Register map (word aligned byte addresses)
	localparam logic [7:0] CPMC_ADDR_CONTROL = 8'h00;
	localparam logic [7:0] CPMC_ADDR_STATE   = 8'h04;
	localparam logic [7:0] CPMC_ADDR_MSP     = 8'h08;
	localparam logic [7:0] CPMC_ADDR_PSP     = 8'h0C;
	localparam logic [7:0] CPMC_ADDR_XSW     = 8'h10;
	localparam logic [7:0] CPMC_ADDR_IRQ_ST  = 8'h14;
	localparam logic [7:0] CPMC_ADDR_IRQ_MSK = 8'h18;

	// ========================================================
	// Field positions
	localparam int CPMC_CTRL_NPRIV_BIT = 0;
	localparam int CPMC_CTRL_SPSEL_BIT = 1;
	localparam int CPMC_XSW_COMPACT_BIT = 24;
	localparam int CPMC_EV_PRIV_FAULT  = 0;
	localparam int CPMC_EV_XSW_FAULT   = 1;
	localparam int CPMC_EV_ISA_FAULT   = 2;
	localparam int CPMC_EV_ENTRY       = 3;
	localparam int CPMC_EV_W           = 4;

	// ========================================================
	// Reset values and stack pointer alignment mask
	localparam logic [1:0]  CPMC_CONTROL_RST = 2'h0;
	localparam logic [31:0] CPMC_SP_RST      = 32'h0000_0000;
	localparam logic [31:0] CPMC_XSW_RST     = 32'h0100_0000;
	localparam logic [31:0] CPMC_SP_ALIGN    = 32'hFFFF_FFFC;

	// ========================================================
	// Operating states
	typedef enum logic [1:0] {
		CPMC_PRIV_THREAD = 2'b00,
		CPMC_USER_THREAD = 2'b01,
		CPMC_PRIV_HANDLER = 2'b10
	} cpmc_state_e;

endpackage

// file: rtl/cpmc_top.sv
// Privilege level, execution mode and stack selection control with Wishbone registers.
`timescale 1ns/1ps
module cpmc_top
	import cpmc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Core side
	input  wire logic        exc_entry_i,
	input  wire logic        exc_return_i,
	input  wire logic        restricted_access_i,
	input  wire logic        legacy_isa_i,
	input  wire logic        sp_write_i,
	input  wire logic [31:0] sp_wdata_i,
	output logic      [31:0] active_sp_o,
	output logic             privileged_o,
	output logic             handler_mode_o,
	output logic             use_process_sp_o,
	output logic             fault_o,
	output logic             irq_o
);

	cpmc_state_e          state_r;
	cpmc_state_e          state_nxt;
	cpmc_state_e          saved_thread_r;
	logic [1:0]           control_r;
	logic [31:0]          main_stack_pointer_r;
	logic [31:0]          process_stack_pointer_r;
	logic [31:0]          execution_status_word_r;
	logic [CPMC_EV_W-1:0] irq_status_r;
	logic [CPMC_EV_W-1:0] irq_mask_r;
	logic [CPMC_EV_W-1:0] events;
	logic                 wb_req;
	logic                 wr_en;
	logic                 priv_fault;
	logic                 xsw_fault;
	logic                 isa_fault;
	logic                 sel_psp;

	// Apply byte enables to a 32-bit word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ========================================================
	// Bus handshake
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en  = wb_req && wb_we_i;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// ========================================================
	// Fault detection
	// Control writes from software are special-register accesses
	assign priv_fault = (state_r == CPMC_USER_THREAD) &&
		(restricted_access_i || (wr_en && wb_adr_i == CPMC_ADDR_CONTROL));
	assign xsw_fault  = wr_en && wb_adr_i == CPMC_ADDR_XSW && wb_sel_i[3] &&
		!wb_dat_i[CPMC_XSW_COMPACT_BIT];
	assign isa_fault  = legacy_isa_i;
	assign fault_o    = priv_fault || xsw_fault || isa_fault;

	// ========================================================
	// Operating state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CPMC_PRIV_THREAD,
			CPMC_USER_THREAD: begin
				if (exc_entry_i || fault_o) begin
					state_nxt = CPMC_PRIV_HANDLER;
				end else begin
					state_nxt = control_r[CPMC_CTRL_NPRIV_BIT] ? CPMC_USER_THREAD : CPMC_PRIV_THREAD;
				end
			end
			CPMC_PRIV_HANDLER: begin
				if (exc_return_i) begin
					state_nxt = saved_thread_r;
				end
			end
			default: state_nxt = CPMC_PRIV_THREAD;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_r <= CPMC_PRIV_THREAD;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			saved_thread_r <= CPMC_PRIV_THREAD;
		end else if (state_r != CPMC_PRIV_HANDLER && state_nxt == CPMC_PRIV_HANDLER) begin
			saved_thread_r <= state_r;
		end
	end

	assign privileged_o   = state_r != CPMC_USER_THREAD;
	assign handler_mode_o = state_r == CPMC_PRIV_HANDLER;

	// ========================================================
	// Control register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			control_r <= CPMC_CONTROL_RST;
		end else if (wr_en && wb_adr_i == CPMC_ADDR_CONTROL && wb_sel_i[0] && privileged_o) begin
			control_r <= wb_dat_i[1:0];
		end
	end

	// ========================================================
	// Stack pointers
	assign sel_psp          = (state_r == CPMC_USER_THREAD) && control_r[CPMC_CTRL_SPSEL_BIT];
	assign use_process_sp_o = sel_psp;
	assign active_sp_o      = sel_psp ? process_stack_pointer_r : main_stack_pointer_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			main_stack_pointer_r <= CPMC_SP_RST;
		end else if (sp_write_i && !sel_psp) begin
			main_stack_pointer_r <= sp_wdata_i & CPMC_SP_ALIGN;
		end else if (wr_en && wb_adr_i == CPMC_ADDR_MSP && privileged_o) begin
			main_stack_pointer_r <= merge_bytes(main_stack_pointer_r, wb_dat_i, wb_sel_i) & CPMC_SP_ALIGN;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			process_stack_pointer_r <= CPMC_SP_RST;
		end else if (sp_write_i && sel_psp) begin
			process_stack_pointer_r <= sp_wdata_i & CPMC_SP_ALIGN;
		end else if (wr_en && wb_adr_i == CPMC_ADDR_PSP && privileged_o) begin
			process_stack_pointer_r <= merge_bytes(process_stack_pointer_r, wb_dat_i, wb_sel_i) & CPMC_SP_ALIGN;
		end
	end

	// ========================================================
	// Execution status word: compact bit held at one
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			execution_status_word_r <= CPMC_XSW_RST;
		end else if (wr_en && wb_adr_i == CPMC_ADDR_XSW && privileged_o) begin
			execution_status_word_r <= merge_bytes(execution_status_word_r, wb_dat_i, wb_sel_i) | CPMC_XSW_RST;
		end
	end

	// ========================================================
	// Interrupt status and mask
	always_comb begin
		events = '0;
		events[CPMC_EV_PRIV_FAULT] = priv_fault;
		events[CPMC_EV_XSW_FAULT]  = xsw_fault;
		events[CPMC_EV_ISA_FAULT]  = isa_fault;
		events[CPMC_EV_ENTRY]      = state_r != CPMC_PRIV_HANDLER && state_nxt == CPMC_PRIV_HANDLER;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_status_r <= '0;
		end else if (wr_en && wb_adr_i == CPMC_ADDR_IRQ_ST && wb_sel_i[0]) begin
			irq_status_r <= (irq_status_r & ~wb_dat_i[CPMC_EV_W-1:0]) | events;
		end else begin
			irq_status_r <= irq_status_r | events;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_mask_r <= '0;
		end else if (wr_en && wb_adr_i == CPMC_ADDR_IRQ_MSK && wb_sel_i[0]) begin
			irq_mask_r <= wb_dat_i[CPMC_EV_W-1:0];
		end
	end

	assign irq_o = |(irq_status_r & irq_mask_r);

	// ========================================================
	// Read data
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				CPMC_ADDR_CONTROL: wb_dat_o <= {30'h0, control_r};
				CPMC_ADDR_STATE:   wb_dat_o <= {29'h0, sel_psp, handler_mode_o, privileged_o};
				CPMC_ADDR_MSP:     wb_dat_o <= main_stack_pointer_r;
				CPMC_ADDR_PSP:     wb_dat_o <= process_stack_pointer_r;
				CPMC_ADDR_XSW:     wb_dat_o <= execution_status_word_r | CPMC_XSW_RST;
				CPMC_ADDR_IRQ_ST:  wb_dat_o <= {28'h0, irq_status_r};
				CPMC_ADDR_IRQ_MSK: wb_dat_o <= {28'h0, irq_mask_r};
				default:           wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// file: bench/cpmc_asserts.sv
// Port-level assertions for the privilege and mode control block.
`timescale 1ns/1ps
module cpmc_asserts (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic exc_entry_i,
	input wire logic exc_return_i,
	input wire logic restricted_access_i,
	input wire logic legacy_isa_i,
	input wire logic privileged_o,
	input wire logic handler_mode_o,
	input wire logic use_process_sp_o,
	input wire logic fault_o
);
	// ========================================================
	// Sequences
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_enter;
		handler_mode_o && privileged_o;
	endsequence
	sequence s_fault_enter;
		fault_o ##1 s_enter;
	endsequence
	// ========================================================
	// Properties
	AST_NO_USER_HANDLER: assert property (handler_mode_o |-> privileged_o)
		else $error("handler mode outside privileged level");
	AST_ENTRY: assert property (exc_entry_i |=> s_enter)
		else $error("exception entry missed handler state");
	AST_USER_FAULT: assert property (restricted_access_i && !privileged_o |-> s_fault_enter)
		else $error("user restricted access not faulted");
	AST_PRIV_OK: assert property (privileged_o && restricted_access_i && !legacy_isa_i && !wb_cyc_i |-> !fault_o)
		else $error("privileged access faulted");
	AST_LEGACY: assert property (legacy_isa_i |-> s_fault_enter)
		else $error("legacy encoding not faulted");
	AST_PSP_USER: assert property (use_process_sp_o |-> !handler_mode_o && !privileged_o)
		else $error("process stack outside user thread");
	AST_RETURN: assert property (handler_mode_o && exc_return_i && !exc_entry_i && !fault_o |=> !handler_mode_o)
		else $error("return did not leave handler");
	AST_RESET: assert property ($fell(rst_i) |-> privileged_o && !handler_mode_o && !use_process_sp_o)
		else $error("bad state after reset");
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not one cycle pulse");
endmodule

// file: bench/cpmc_top_tb.sv
// Self-checking bench for the privilege and mode control block.
`timescale 1ns/1ps
module cpmc_top_tb;
	import cpmc_pkg::*;
	logic mclk_i = 0, rst_i = 1, cyc = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, q, wb_dat_o, active_sp_o;
	logic [3:0] ev = 4'h0, sel = 4'hF;
	logic sw = 1'b0;
	logic [31:0] swd = 32'h0;
	logic wb_ack_o, privileged_o, handler_mode_o, use_process_sp_o, fault_o, irq_o;
	int fails = 0, cmp_count = 0;
	always #20 mclk_i = ~mclk_i;
	cpmc_top i_cpmc_top (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.exc_entry_i(ev[0]), .exc_return_i(ev[1]), .restricted_access_i(ev[2]), .legacy_isa_i(ev[3]),
		.sp_write_i(sw), .sp_wdata_i(swd), .active_sp_o(active_sp_o), .privileged_o(privileged_o),
		.handler_mode_o(handler_mode_o), .use_process_sp_o(use_process_sp_o), .fault_o(fault_o), .irq_o(irq_o));
	// ========================================================
	// Tasks
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		cyc <= 1'b1; we <= w; adr <= a; wd <= d;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			wrap_up();
		end
		q = wb_dat_o;
		cyc <= 1'b0; we <= 1'b0;
	endtask
	task rd(input string s, input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask
	// Pulses core events for one cycle and checks the fault flag in that cycle
	task pulse(input logic [3:0] v, input logic f);
		@(posedge mclk_i);
		ev <= v;
		#1 chk("fault", {31'h0, f}, {31'h0, fault_o});
		@(posedge mclk_i);
		ev <= 4'h0;
		#1;
	endtask
	// ========================================================
	// Sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1 chk("priv", 32'h1, {31'h0, privileged_o});
		rd("state", CPMC_ADDR_STATE, 32'h1);
		rd("xsw", CPMC_ADDR_XSW, CPMC_XSW_RST);
		rd("unmapped", 8'h1C, 32'h0);
		$display("Test reset done");
		acc(1'b1, CPMC_ADDR_MSP, 32'h1111_0000);
		acc(1'b1, CPMC_ADDR_PSP, 32'h2222_0000);
		rd("psp", CPMC_ADDR_PSP, 32'h2222_0000);
		acc(1'b1, CPMC_ADDR_CONTROL, 32'h3);
		#1 chk("user", 32'h1, {31'h0, use_process_sp_o & ~privileged_o});
		chk("sp", 32'h2222_0000, active_sp_o);
		@(posedge mclk_i);
		sw <= 1'b1; swd <= 32'h2222_0013;
		@(posedge mclk_i);
		sw <= 1'b0;
		#1 chk("sp", 32'h2222_0010, active_sp_o);
		$display("Test stacks done");
		pulse(4'h4, 1'b1);
		chk("handler", 32'h3, {30'h0, handler_mode_o, privileged_o});
		chk("sp", 32'h1111_0000, active_sp_o);
		rd("status", CPMC_ADDR_IRQ_ST, 32'h9);
		acc(1'b1, CPMC_ADDR_IRQ_MSK, 32'h9);
		#1 chk("irq", 32'h1, {31'h0, irq_o});
		acc(1'b1, CPMC_ADDR_IRQ_ST, 32'h9);
		#1 chk("irq", 32'h0, {31'h0, irq_o});
		pulse(4'h2, 1'b0);
		chk("thread", 32'h0, {30'h0, handler_mode_o, privileged_o});
		$display("Test user fault done");
		acc(1'b1, CPMC_ADDR_CONTROL, 32'h0);
		rd("control", CPMC_ADDR_CONTROL, 32'h3);
		pulse(4'h2, 1'b0);
		pulse(4'h1, 1'b0);
		pulse(4'h4, 1'b0);
		pulse(4'h8, 1'b1);
		sel <= 4'h7;
		acc(1'b1, CPMC_ADDR_XSW, 32'h0000_00AB);
		sel <= 4'hF;
		rd("xsw", CPMC_ADDR_XSW, 32'h0100_00AB);
		rd("status", CPMC_ADDR_IRQ_ST, 32'hD);
		acc(1'b1, CPMC_ADDR_XSW, 32'h0);
		rd("xsw", CPMC_ADDR_XSW, CPMC_XSW_RST);
		rd("status", CPMC_ADDR_IRQ_ST, 32'hF);
		$display("Test handler done");
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		fails++;
		wrap_up();
	end
endmodule
bind cpmc_top cpmc_asserts i_cpmc_asserts (.*);
